/* File: core/nmr_pkg.sv */
// constants and types for the negative multiply-accumulate, logic and rotate unit
// Functional notes
// - high halfwords multiplied, negated, added, 33 bits
// - saturating forms write low 32 if fitting
// - overflow clamps to old sign, inverted bits
// - low halfwords multiplied, negated, added, 33 bits
// - modulo low form drops top bit
// - saturating low form clamps on overflow
// - overflow enable updates summary and overflow bits
// - record bit updates condition field zero
// - nor inverts or of sources
// - or writes bitwise or
// - or with complement of second source
// - or immediate zero extended low half
// - or immediate shifted into upper half
// - or immediate all zero is no-op
// - rotate left, mask from begin to end
// - mask wraps when begin exceeds end
// - insert form keeps bits outside mask
// - and form clears bits outside mask
package nmr_pkg;
    localparam logic [5:0]  OP_MAC         = 6'h04;
    localparam logic [5:0]  OP_LOGIC       = 6'h1f;
    localparam logic [5:0]  OP_OR_IMM      = 6'h18;
    localparam logic [5:0]  OP_OR_IMM_HI   = 6'h19;
    localparam logic [5:0]  OP_ROT_INS     = 6'h14;
    localparam logic [5:0]  OP_ROT_AND     = 6'h15;
    localparam logic [8:0]  XO_NMAC_HI_SAT = 9'h06e;
    localparam logic [8:0]  XO_NMAC_LO     = 9'h1ae;
    localparam logic [8:0]  XO_NMAC_LO_SAT = 9'h1ee;
    localparam logic [9:0]  XO_NOR         = 10'h07c;
    localparam logic [9:0]  XO_OR          = 10'h1bc;
    localparam logic [9:0]  XO_OR_CMP      = 10'h19c;
    localparam logic [31:0] RST_WORD       = 32'h0000_0000;

    typedef struct packed {
        logic        lt;
        logic        gt;
        logic        eq;
        logic        so;
    } nmr_cr_t;

    typedef struct packed {
        logic        so;
        logic        ovf;
    } nmr_fxe_t;

    typedef struct packed {
        logic        valid;
        logic [31:0] data;
        logic        cr_we;
        nmr_cr_t     cr;
        logic        fxe_we;
        nmr_fxe_t    fxe;
        logic        nop;
        logic        illegal;
    } nmr_result_t;
endpackage

/* File: core/nmr_unit.sv */
// single-cycle execution unit: negative mac, or family, rotate with mask
`timescale 1ns/100ps
module nmr_unit (
    // clock and reset
    input  wire logic                clk_sys,
    input  wire logic                sys_rst,
    // instruction and operands from decode
    input  wire logic                issue_valid,
    input  wire logic [31:0]         instr_word,
    input  wire logic [31:0]         first_source_register,
    input  wire logic [31:0]         second_source_register,
    input  wire logic [31:0]         source_register,
    input  wire logic [31:0]         target_register,
    input  wire nmr_pkg::nmr_fxe_t   fixed_point_exception_reg,
    // result towards register file
    output nmr_pkg::nmr_result_t     result_ff
);
    // instruction bit i (bit 0 = msb) sits at instr_word[31-i]
    logic [5:0]  opcd;
    logic [9:0]  xo10;
    logic [8:0]  xo9;
    logic        record_bit;
    logic        oe_bit;
    logic [4:0]  shift_amount_field;
    logic [4:0]  mask_begin_field;
    logic [4:0]  mask_end_field;
    logic [15:0] immediate_field;
    logic [4:0]  fld_d;
    logic [4:0]  fld_a;

    assign opcd               = instr_word[31:26];
    assign fld_d              = instr_word[25:21];
    assign fld_a              = instr_word[20:16];
    assign shift_amount_field = instr_word[15:11];
    assign mask_begin_field   = instr_word[10:6];
    assign mask_end_field     = instr_word[5:1];
    assign xo10               = instr_word[10:1];
    assign xo9                = instr_word[9:1];
    assign oe_bit             = instr_word[10];
    assign record_bit         = instr_word[0];
    assign immediate_field    = instr_word[15:0];

    // multiply-accumulate datapath
    logic signed [15:0] ha;
    logic signed [15:0] hb;
    logic signed [31:0] prod;
    logic [31:0]        nprod;
    logic [32:0]        temp;
    logic               mac_ovf;
    logic               is_hhws;
    logic               is_lhw;
    logic               is_lhws;
    logic               is_mac;
    logic               is_sat;
    logic [31:0]        mac_res;
    logic               sat_ovf;

    assign is_hhws = (opcd == nmr_pkg::OP_MAC) && (xo9 == nmr_pkg::XO_NMAC_HI_SAT);
    assign is_lhw  = (opcd == nmr_pkg::OP_MAC) && (xo9 == nmr_pkg::XO_NMAC_LO);
    assign is_lhws = (opcd == nmr_pkg::OP_MAC) && (xo9 == nmr_pkg::XO_NMAC_LO_SAT);
    assign is_mac  = is_hhws | is_lhw | is_lhws;
    assign is_sat  = is_hhws | is_lhws;

    // msb-numbered 0:15 is the upper half, 16:31 the lower half
    assign ha    = is_hhws ? first_source_register[31:16]
                           : first_source_register[15:0];
    assign hb    = is_hhws ? second_source_register[31:16]
                           : second_source_register[15:0];
    assign prod  = ha * hb;
    assign nprod = 32'h0 - prod;
    assign temp  = {nprod[31], nprod} + {target_register[31], target_register};
    // temp bit 1 in msb numbering is temp[31]
    assign mac_ovf = (nprod[31] == target_register[31])
                   && (target_register[31] != temp[31]);
    // only the saturating forms report overflow; the modulo form wraps silently
    assign sat_ovf = is_sat & mac_ovf;

    always_comb begin
        if (is_sat && mac_ovf) begin
            mac_res = {target_register[31], {31{~target_register[31]}}};
        end else begin
            mac_res = temp[31:0];
        end
    end

    // rotate with mask: msb-numbered mask, built in msb order then mapped
    logic [31:0] rot;
    logic [31:0] mask;
    logic [63:0] rot_dbl;

    assign rot_dbl = {source_register, source_register} << shift_amount_field;
    assign rot     = rot_dbl[63:32];

    genvar gi;
    generate
        for (gi = 0; gi < 32; gi++) begin : g_mask
            // position gi in msb numbering is mask[31-gi]
            localparam logic [4:0] POS = 5'(gi);
            assign mask[31-gi] = (mask_begin_field <= mask_end_field)
                ? ((POS >= mask_begin_field) && (POS <= mask_end_field))
                : ((POS >= mask_begin_field) || (POS <= mask_end_field));
        end
    endgenerate

    // operation select and result
    nmr_pkg::nmr_result_t nxt_result;
    logic [31:0]          res;
    logic                 known;
    logic                 rec;
    logic                 ovf_upd;
    nmr_pkg::nmr_fxe_t    fxe_new;

    always_comb begin
        res     = nmr_pkg::RST_WORD;
        known   = 1'b1;
        rec     = 1'b0;
        ovf_upd = 1'b0;
        unique case (opcd)
            nmr_pkg::OP_MAC: begin
                known   = is_mac;
                res     = mac_res;
                rec     = record_bit;
                ovf_upd = is_mac && oe_bit;
            end
            nmr_pkg::OP_LOGIC: begin
                rec = record_bit;
                unique case (xo10)
                    nmr_pkg::XO_NOR: res = ~(source_register | second_source_register);
                    nmr_pkg::XO_OR:  res = source_register | second_source_register;
                    nmr_pkg::XO_OR_CMP: res = source_register | ~second_source_register;
                    default:         known = 1'b0;
                endcase
            end
            nmr_pkg::OP_OR_IMM:    res = source_register | {16'h0000, immediate_field};
            nmr_pkg::OP_OR_IMM_HI: res = source_register | {immediate_field, 16'h0000};
            nmr_pkg::OP_ROT_INS: begin
                res = (rot & mask) | (target_register & ~mask);
                rec = record_bit;
            end
            nmr_pkg::OP_ROT_AND: begin
                res = rot & mask;
                rec = record_bit;
            end
            default: known = 1'b0;
        endcase
    end

    always_comb begin
        fxe_new.ovf = ovf_upd ? sat_ovf : fixed_point_exception_reg.ovf;
        fxe_new.so  = fixed_point_exception_reg.so | (ovf_upd & sat_ovf);
        nxt_result          = '0;
        nxt_result.valid    = issue_valid;
        nxt_result.illegal  = issue_valid & ~known;
        if (issue_valid && known) begin
            nxt_result.data   = res;
            nxt_result.fxe_we = ovf_upd;
            nxt_result.fxe    = fxe_new;
            nxt_result.cr_we  = rec;
            nxt_result.cr.lt  = res[31];
            nxt_result.cr.gt  = ~res[31] & (res != 32'h0);
            nxt_result.cr.eq  = (res == 32'h0);
            nxt_result.cr.so  = fxe_new.so;
            nxt_result.nop    = (opcd == nmr_pkg::OP_OR_IMM) && (fld_d == 5'h00)
                              && (fld_a == 5'h00) && (immediate_field == 16'h0000);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            result_ff <= '0;
        end else begin
            result_ff <= nxt_result;
        end
    end
endmodule

/* File: dv/nmr_dec_model.sv */
// decode-side model: one instruction and its operands per cycle
`timescale 1ns/100ps
module nmr_dec_model (
    // clock
    input wire logic          clk_sys,
    // issue towards the unit
    output logic              iv,
    output logic [31:0]       iw,
    output logic [31:0]       src_a,
    output logic [31:0]       src_b,
    output logic [31:0]       src_s,
    output logic [31:0]       dst_t,
    output nmr_pkg::nmr_fxe_t xr
);
    initial {iv, iw, src_a, src_b, src_s, dst_t, xr} = '0;
    task automatic put(input logic [31:0] w, a, b, s, t, input logic [1:0] x, input logic v);
        @(negedge clk_sys);
        {iv, iw, src_a, src_b, src_s, dst_t, xr} = {v, w, a, b, s, t, x};
    endtask
endmodule

/* File: dv/nmr_unit_chk.sv */
// bound checker on the execution unit ports
`timescale 1ns/100ps
module nmr_unit_chk (
    // clock and reset
    input wire logic                 clk_sys,
    input wire logic                 sys_rst,
    // issue side
    input wire logic                 issue_valid,
    input wire logic [31:0]          instr_word,
    input wire logic [31:0]          first_source_register,
    input wire logic [31:0]          second_source_register,
    input wire logic [31:0]          source_register,
    input wire logic [31:0]          target_register,
    // registered result
    input wire nmr_pkg::nmr_result_t result_ff
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    logic [5:0]           op;
    logic [31:0]          w;
    logic [31:0]          s;
    logic [31:0]          b;
    nmr_pkg::nmr_result_t r;
    assign op = issue_valid ? instr_word[31:26] : 6'h3f;
    assign w = instr_word;
    assign s = source_register;
    assign b = second_source_register;
    assign r = result_ff;
    AST_MAC_LO: assert property (op == 6'h04 && w[9:1] == 9'h1ae |=> !(r.fxe_we && r.fxe.ovf) &&
        r.data == $past(target_register - int'($signed(first_source_register[15:0])) *
        int'($signed(b[15:0])))) else $error("modulo low accumulate wrong");
    AST_SAT: assert property (r.fxe_we && r.fxe.ovf |-> r.data == {$past(target_register[31]),
        {31{!$past(target_register[31])}}}) else $error("clamp value wrong");
    AST_OVF_EN: assert property (op == 6'h04 |=> r.fxe_we == ($past(w[10]) && !r.illegal))
        else $error("overflow update enable wrong");
    AST_CR: assert property (r.cr_we |-> r.cr.eq == (r.data == 0) && r.cr.lt == r.data[31] &&
        r.cr.gt == (!r.data[31] && r.data != 0)) else $error("condition bits wrong");
    AST_NOR: assert property (op == 6'h1f && w[10:1] == 10'h07c |=> r.data == ~$past(s | b))
        else $error("nor result wrong");
    AST_OR_CMP: assert property (op == 6'h1f && w[10:1] == 10'h19c |=> r.data == $past(s | ~b))
        else $error("or complement result wrong");
    AST_OR_IMM: assert property (op == 6'h18 |=> !r.cr_we && !r.fxe_we &&
        r.data == $past(s | {16'h0, w[15:0]})) else $error("or immediate wrong");
    AST_NOP: assert property (issue_valid && w == 32'h6000_0000 |=> r.nop && r.data == $past(s))
        else $error("no-operation flag wrong");
    cover property (r.fxe_we && r.fxe.ovf);
    cover property (r.nop);
    cover property (r.illegal);
endmodule
bind nmr_unit nmr_unit_chk u_chk (.clk_sys, .sys_rst, .issue_valid, .instr_word,
    .first_source_register, .second_source_register, .source_register, .target_register,
    .result_ff);

/* File: dv/tb_nmr_unit.sv */
// self-checking bench: random and corner instructions against a reference
`timescale 1ns/100ps
module tb_nmr_unit;
    logic                 clk_sys;
    logic                 sys_rst;
    logic                 iv;
    logic [31:0]          iw, src_a, src_b, src_s, dst_t;
    nmr_pkg::nmr_fxe_t    xr;
    nmr_pkg::nmr_result_t res;
    logic [42:0]          exp_q;
    logic                 pend = 1'b0;
    int                   failures = 0, n_checks = 0, cyc = 0;
    logic [5:0]           opt [12] = '{4, 4, 4, 31, 31, 31, 24, 25, 20, 21, 0, 4};
    logic [9:0]           xot [12] = '{110, 430, 494, 124, 444, 412, 0, 0, 0, 0, 0, 255};
    nmr_dec_model u_dec (.clk_sys, .iv, .iw, .src_a, .src_b, .src_s, .dst_t, .xr);
    nmr_unit dut (.clk_sys, .sys_rst, .issue_valid(iv), .instr_word(iw),
        .first_source_register(src_a), .second_source_register(src_b),
        .source_register(src_s), .target_register(dst_t), .fixed_point_exception_reg(xr),
        .result_ff(res));
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    function automatic logic [42:0] ref_key(logic [31:0] w, a, b, s, t, logic [1:0] x);
        logic [31:0] d, r, m, np;
        logic [32:0] tp;
        logic        ill, ovf, so, crw, xw;
        {d, ill, ovf, xw} = '0;
        crw = w[0];
        r = (s << w[15:11]) | (s >> (6'h20 - w[15:11]));
        for (int k = 0; k < 32; k++)
            m[31-k] = w[10:6] <= w[5:1] ? k >= w[10:6] && k <= w[5:1] : k >= w[10:6] || k <= w[5:1];
        case (w[31:26])
            nmr_pkg::OP_MAC: begin
                if (w[9:1] == nmr_pkg::XO_NMAC_HI_SAT)
                    np = -($signed(a[31:16]) * $signed(b[31:16]));
                else
                    np = -($signed(a[15:0]) * $signed(b[15:0]));
                tp = {np[31], np} + {t[31], t};
                ovf = np[31] == t[31] && t[31] != tp[31] && w[9:1] != nmr_pkg::XO_NMAC_LO;
                d = ovf ? {t[31], {31{~t[31]}}} : tp[31:0];
                xw = w[10];
                ill = !(w[9:1] inside {nmr_pkg::XO_NMAC_HI_SAT, nmr_pkg::XO_NMAC_LO,
                    nmr_pkg::XO_NMAC_LO_SAT});
            end
            nmr_pkg::OP_LOGIC: begin
                if (w[10:1] == nmr_pkg::XO_NOR)
                    d = ~(s | b);
                else if (w[10:1] == nmr_pkg::XO_OR)
                    d = s | b;
                else
                    d = s | ~b;
                ill = !(w[10:1] inside {nmr_pkg::XO_NOR, nmr_pkg::XO_OR, nmr_pkg::XO_OR_CMP});
            end
            nmr_pkg::OP_OR_IMM: {d, crw} = {s | {16'h0, w[15:0]}, 1'b0};
            nmr_pkg::OP_OR_IMM_HI: {d, crw} = {s | {w[15:0], 16'h0}, 1'b0};
            nmr_pkg::OP_ROT_INS: d = (r & m) | (t & ~m);
            nmr_pkg::OP_ROT_AND: d = r & m;
            default: ill = 1'b1;
        endcase
        if (ill) {d, crw, xw} = '0;
        so = x[1] | (xw & ovf);
        return {1'b1, ill, w == 32'h6000_0000, crw, crw ? {$signed(d) < 0, $signed(d) > 0,
            d == 0, so} : 4'h0, xw, xw ? {so, ovf} : 2'h0, d};
    endfunction
    task automatic chk(input logic [42:0] e);
        logic [42:0] a;
        a = {res.valid, res.illegal, res.nop, res.cr_we, res.cr_we ? res.cr : 4'h0,
            res.fxe_we, res.fxe_we ? res.fxe : 2'h0, res.data};
        if (!e[42]) a = {res.valid, 42'h0};
        n_checks++;
        if (a !== e) begin
            failures++;
            $display("ERROR result expected %h seen %h", e, a);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        if (pend) chk(exp_q);
        pend = !sys_rst;
        exp_q = iv ? ref_key(iw, src_a, src_b, src_s, dst_t, xr) : 43'h0;
        cyc++;
        if (cyc == 2000) begin
            failures++;
            give_verdict();
        end
    end
    initial begin
        logic [31:0] w;
        int          k;
        void'($urandom(52));
        sys_rst = 1'b1;
        repeat (2) @(negedge clk_sys);
        sys_rst = 1'b0;
        u_dec.put(32'h6000_0000, 0, 0, 0, 0, 0, 1);
        u_dec.put(32'h1000_04dd, 32'h8000_0000, 32'h8000_0000, 0, 32'h8000_0000, 0, 1);
        u_dec.put(32'h1000_07dd, 32'h8000, 32'h7fff, 0, 32'h7fff_ffff, 2'h2, 1);
        u_dec.put(32'h5400_2707, $urandom(), 0, $urandom(), 0, 0, 1);
        u_dec.put(32'h5000_2707, 0, 0, $urandom(), $urandom(), 0, 1);
        repeat (400) begin
            k = $urandom_range(11);
            w = $urandom();
            w[31:26] = opt[k];
            if (k < 3 || k == 11) w[9:1] = xot[k][8:0];
            if (k inside {[3:5]}) w[10:1] = xot[k];
            u_dec.put(w, $urandom(), $urandom(), $urandom(), $urandom(), 2'($urandom()),
                $urandom_range(3) != 0);
        end
        u_dec.put(0, 0, 0, 0, 0, 0, 0);
        repeat (2) @(negedge clk_sys);
        give_verdict();
    end
endmodule
